/* rtl/zolc_pkg.sv */
// zolc_pkg: shared constants and types for the zero-overhead loop control.
// assumes one core clock and a 32-bit classic wishbone register port.
`default_nettype none
package zolc_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ZOLC_AW = 24;
    localparam int ZOLC_CW = 16;
    localparam int ZOLC_WB_AW = 5;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] ZOLC_REG_CSR = 5'h00;
    localparam logic [4:0] ZOLC_REG_ACTIVE_SINGLE_REPEAT_COUNTER = 5'h04;
    localparam logic [4:0] ZOLC_REG_OUTER = 5'h08;
    localparam logic [4:0] ZOLC_REG_INNER = 5'h0C;
    localparam logic [4:0] ZOLC_REG_SHADOW = 5'h10;
    localparam logic [4:0] ZOLC_REG_STATUS = 5'h14;
    // ------------------------------------------------------------
    // status field positions and reset values
    // ------------------------------------------------------------
    localparam int ZOLC_ST_RPT = 0;
    localparam int ZOLC_ST_LVL0 = 1;
    localparam int ZOLC_ST_LVL1 = 2;
    localparam int ZOLC_ST_LOC0 = 3;
    localparam int ZOLC_ST_LOC1 = 4;
    localparam int ZOLC_ST_PEND = 5;
    localparam logic [15:0] ZOLC_CNT_RST = 16'h0000;
    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam logic [2:0] ZOLC_BR_OVH_CYC = 3'h5;
    localparam logic [1:0] ZOLC_LC_PEND_CYC = 2'h3;
    // ------------------------------------------------------------
    // decoded loop operations, one-hot except ZOLC_OP_NONE
    // ------------------------------------------------------------
    typedef enum logic [10:0] {
        ZOLC_OP_NONE = 11'h000,
        ZOLC_OP_RPT_K = 11'h001,
        ZOLC_OP_RPT_CSR = 11'h002,
        ZOLC_OP_RPT_CSR_TA = 11'h004,
        ZOLC_OP_RPT_CSR_K4 = 11'h008,
        ZOLC_OP_BLK_LOCAL = 11'h010,
        ZOLC_OP_BLK_STD = 11'h020,
        ZOLC_OP_BR_AUX = 11'h040,
        ZOLC_OP_WR_CSR = 11'h080,
        ZOLC_OP_WR_OUTER = 11'h100,
        ZOLC_OP_WR_INNER = 11'h200,
        ZOLC_OP_RD_LC = 11'h400
    } zolc_op_t;
    typedef enum logic [1:0] {
        ZOLC_RPT_IDLE = 2'h1,
        ZOLC_RPT_RUN = 2'h2
    } zolc_rpt_st_t;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        zolc_op_t op;
        logic [ZOLC_CW-1:0] imm;
        logic [ZOLC_AW-1:0] addr;
        logic [ZOLC_AW-1:0] pc;
    } zolc_dec_t;
    typedef struct packed {
        logic valid;
        logic from_queue;
        logic [ZOLC_AW-1:0] target;
    } zolc_redir_t;
endpackage
`default_nettype wire

/* rtl/zolc_level.sv */
// zolc_level: one block-repeat level with counter, bounds and optional shadow.
// assumes the top gates pc_valid so the outer level does not see an end address that the inner level hits.
`default_nettype none
module zolc_level #(
    parameter bit HAS_SHADOW = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic start_local,
    input wire logic [zolc_pkg::ZOLC_AW-1:0] start_pc,
    input wire logic [zolc_pkg::ZOLC_AW-1:0] end_pc,
    input wire logic wr_en,
    input wire logic [zolc_pkg::ZOLC_CW-1:0] wr_val,
    input wire logic pc_valid,
    input wire logic [zolc_pkg::ZOLC_AW-1:0] pc,
    output logic active,
    output logic local_mode,
    output logic hit,
    output logic end_seen,
    output logic [zolc_pkg::ZOLC_AW-1:0] loop_start,
    output logic [zolc_pkg::ZOLC_CW-1:0] count,
    output logic [zolc_pkg::ZOLC_CW-1:0] shadow
);
    import zolc_pkg::*;
    logic [ZOLC_AW-1:0] end_r;

    assign end_seen = active && pc_valid && (pc == end_r);
    assign hit = end_seen && (count != ZOLC_CNT_RST); // RQ22

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= 1'b0;
            local_mode <= 1'b0;
            loop_start <= '0;
            end_r <= '0;
        end else if (start) begin
            active <= 1'b1;
            local_mode <= start_local;
            loop_start <= start_pc;
            end_r <= end_pc;
        end else if (end_seen && count == ZOLC_CNT_RST) begin
            active <= 1'b0; // RQ21
        end
    end

    // a write wins over the iteration decrement
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= ZOLC_CNT_RST;
            shadow <= ZOLC_CNT_RST;
        end else if (wr_en) begin
            count <= wr_val;
            if (HAS_SHADOW) begin
                shadow <= wr_val; // RQ14
            end
        end else if (hit) begin
            count <= count - 16'h0001; // RQ13
        end else if (end_seen && HAS_SHADOW) begin
            count <= shadow; // RQ14
        end
    end
endmodule
`default_nettype wire

/* rtl/zolc_top.sv */
// zolc_top: loop sequencing between instruction queue and execute pipeline.
// assumes decode holds its request until dec_ready and pulses exec_done once
// per executed iteration of a single-repeat instruction.
`default_nettype none
// How it works
// RQ1: repeats add no cycles, aux branch five
// RQ2: single repeat covers one slot, interruptible
// RQ3: repeat count from constant or computed register
// RQ4: computed count never decremented by iterations
// RQ5: copy computed count first, then decrement active
// RQ6: optional extension adds temp or k4 afterwards
// RQ7: newest computed count used at next start
// RQ8: local block repeat runs from instruction queue
// RQ9: software keeps local bodies within 56 bytes
// RQ10: standard block repeat always refetches memory
// RQ11: two nested block levels, no penalty
// RQ12: single repeats allowed inside either level
// RQ13: outer and inner levels own separate counters
// RQ14: shadow restores inner counter on restart
// RQ15: software initialises block counters outside loops
// RQ16: software initialises computed count once outside
// RQ17: software preloads aux pointer with n minus one
// RQ18: stall on competing loop-control register access
// RQ19: aux branch decrements pointer in address phase
// RQ20: constant loop-control writes in address phase
// RQ21: count n-1 runs body n times, falls through
// RQ22: end address with nonzero count jumps to start
module zolc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [zolc_pkg::ZOLC_WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire zolc_pkg::zolc_dec_t dec,
    input wire logic exec_done,
    input wire logic irq_pending,
    input wire logic [zolc_pkg::ZOLC_CW-1:0] temp_addend_register,
    input wire logic [zolc_pkg::ZOLC_CW-1:0] aux_pointer,
    output logic dec_ready,
    output logic rpt_hold,
    output zolc_pkg::zolc_redir_t redir,
    output logic aux_wr,
    output logic [zolc_pkg::ZOLC_CW-1:0] aux_pointer_nxt
);
    import zolc_pkg::*;

    // ------------------------------------------------------------
    // decode acceptance and stall
    // ------------------------------------------------------------
    logic [ZOLC_CW-1:0] computed_repeat_count;
    logic [ZOLC_CW-1:0] active_single_repeat_counter;
    zolc_rpt_st_t rpt_st_r;
    logic [2:0] ovh_r;
    logic [1:0] lc_pend_r;
    logic take;
    logic is_lc_op;
    logic lc_conflict;
    logic rpt_start;
    logic [ZOLC_CW-1:0] rpt_load;

    function automatic logic touches_lc(input zolc_op_t op);
        touches_lc = (op == ZOLC_OP_WR_CSR) || (op == ZOLC_OP_WR_OUTER) || (op == ZOLC_OP_WR_INNER)
                     || (op == ZOLC_OP_RD_LC) || (op == ZOLC_OP_RPT_CSR) || (op == ZOLC_OP_RPT_CSR_TA)
                     || (op == ZOLC_OP_RPT_CSR_K4);
    endfunction

    function automatic logic is_rpt(input zolc_op_t op);
        is_rpt = (op == ZOLC_OP_RPT_K) || (op == ZOLC_OP_RPT_CSR) || (op == ZOLC_OP_RPT_CSR_TA)
                 || (op == ZOLC_OP_RPT_CSR_K4);
    endfunction

    assign is_lc_op = touches_lc(dec.op);
    assign lc_conflict = is_lc_op && (lc_pend_r != 2'h0); // RQ18
    // loop ops are refused while a repeat runs or branch overhead is paid
    assign take = dec.valid && (rpt_st_r == ZOLC_RPT_IDLE) && (ovh_r == 3'h0) && !lc_conflict;
    assign rpt_start = take && is_rpt(dec.op); // RQ12

    // ready goes low one cycle after a blocking event; decode must hold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dec_ready <= 1'b0;
        end else begin
            dec_ready <= !(rpt_start || (take && dec.op == ZOLC_OP_BR_AUX))
                         && (rpt_st_r == ZOLC_RPT_IDLE || (exec_done && active_single_repeat_counter == 16'h0000))
                         && (ovh_r <= 3'h1) && !(take && is_lc_op) && (lc_pend_r <= 2'h1); // RQ18
        end
    end

    // pending window after any taken loop-control op other than a read; bus writes open none
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lc_pend_r <= 2'h0;
        end else if (take && is_lc_op && dec.op != ZOLC_OP_RD_LC) begin
            lc_pend_r <= ZOLC_LC_PEND_CYC; // RQ18
        end else if (lc_pend_r != 2'h0) begin
            lc_pend_r <= lc_pend_r - 2'h1;
        end
    end

    // ------------------------------------------------------------
    // single repeat
    // ------------------------------------------------------------
    always_comb begin
        rpt_load = computed_repeat_count; // RQ7
        if (dec.op == ZOLC_OP_RPT_K) begin
            rpt_load = dec.imm; // RQ3
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rpt_st_r <= ZOLC_RPT_IDLE;
            active_single_repeat_counter <= ZOLC_CNT_RST;
        end else begin
            unique case (rpt_st_r)
                ZOLC_RPT_IDLE: begin
                    if (rpt_start) begin
                        active_single_repeat_counter <= rpt_load; // RQ5
                        rpt_st_r <= ZOLC_RPT_RUN;
                    end
                end
                ZOLC_RPT_RUN: begin
                    if (exec_done) begin
                        if (active_single_repeat_counter == 16'h0000) begin
                            rpt_st_r <= ZOLC_RPT_IDLE; // RQ21
                        end else begin
                            active_single_repeat_counter <= active_single_repeat_counter - 16'h0001; // RQ5
                        end
                    end
                end
            endcase
        end
    end

    // hold drops while an interrupt is pending; counter keeps its place
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rpt_hold <= 1'b0;
        end else begin
            rpt_hold <= (rpt_start || (rpt_st_r == ZOLC_RPT_RUN
                         && !(exec_done && active_single_repeat_counter == 16'h0000))) && !irq_pending; // RQ2 RQ1
        end
    end

    // ------------------------------------------------------------
    // computed count register
    // ------------------------------------------------------------
    logic bus_wr;
    logic [31:0] bus_wdat;

    // iterations never touch this register; only writes and the extension
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            computed_repeat_count <= ZOLC_CNT_RST;
        end else if (take && dec.op == ZOLC_OP_WR_CSR) begin
            computed_repeat_count <= dec.imm; // RQ20
        end else if (take && dec.op == ZOLC_OP_RPT_CSR_TA) begin
            computed_repeat_count <= computed_repeat_count + temp_addend_register; // RQ6
        end else if (take && dec.op == ZOLC_OP_RPT_CSR_K4) begin
            computed_repeat_count <= computed_repeat_count + {12'h000, dec.imm[3:0]}; // RQ6
        end else if (bus_wr && wb_adr_i == ZOLC_REG_CSR) begin
            computed_repeat_count <= bus_wdat[15:0]; // RQ7 RQ4
        end
    end

    // ------------------------------------------------------------
    // block repeat levels
    // ------------------------------------------------------------
    logic l0_active, l1_active, l0_local, l1_local;
    logic l0_hit, l1_hit, l0_end, l1_end;
    logic [ZOLC_AW-1:0] l0_start, l1_start;
    logic [ZOLC_CW-1:0] outer_block_counter, inner_block_counter, inner_count_shadow;
    logic blk_start, blk_local;
    logic l0_wr, l1_wr;
    logic [ZOLC_CW-1:0] l0_wval, l1_wval;

    assign blk_local = (dec.op == ZOLC_OP_BLK_LOCAL); // RQ8
    assign blk_start = take && (blk_local || dec.op == ZOLC_OP_BLK_STD);
    assign l0_wr = (take && dec.op == ZOLC_OP_WR_OUTER) || (bus_wr && wb_adr_i == ZOLC_REG_OUTER); // RQ20
    assign l1_wr = (take && dec.op == ZOLC_OP_WR_INNER) || (bus_wr && wb_adr_i == ZOLC_REG_INNER); // RQ20
    assign l0_wval = (take && dec.op == ZOLC_OP_WR_OUTER) ? dec.imm : bus_wdat[15:0];
    assign l1_wval = (take && dec.op == ZOLC_OP_WR_INNER) ? dec.imm : bus_wdat[15:0];

    zolc_level #(.HAS_SHADOW(1'b0)) u_outer (
        .clk(clk),
        .rst(rst),
        .start(blk_start && !l0_active), // RQ11
        .start_local(blk_local),
        .start_pc(dec.pc),
        .end_pc(dec.addr),
        .wr_en(l0_wr),
        .wr_val(l0_wval),
        .pc_valid(dec.valid && !l1_hit),
        .pc(dec.pc),
        .active(l0_active),
        .local_mode(l0_local),
        .hit(l0_hit),
        .end_seen(l0_end),
        .loop_start(l0_start),
        .count(outer_block_counter),
        .shadow()
    );

    zolc_level #(.HAS_SHADOW(1'b1)) u_inner (
        .clk(clk),
        .rst(rst),
        .start(blk_start && l0_active && !l1_active), // RQ11
        .start_local(blk_local),
        .start_pc(dec.pc),
        .end_pc(dec.addr),
        .wr_en(l1_wr),
        .wr_val(l1_wval),
        .pc_valid(dec.valid),
        .pc(dec.pc),
        .active(l1_active),
        .local_mode(l1_local),
        .hit(l1_hit),
        .end_seen(l1_end),
        .loop_start(l1_start),
        .count(inner_block_counter),
        .shadow(inner_count_shadow)
    );

    // ------------------------------------------------------------
    // redirect and aux-pointer branch
    // ------------------------------------------------------------
    // inner level is checked first so an inner end inside the outer body wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            redir <= '0;
        end else if (l1_hit) begin
            redir <= '{valid: 1'b1, from_queue: l1_local, target: l1_start}; // RQ22 RQ8 RQ10
        end else if (l0_hit) begin
            redir <= '{valid: 1'b1, from_queue: l0_local, target: l0_start}; // RQ22 RQ8 RQ10
        end else if (take && dec.op == ZOLC_OP_BR_AUX && aux_pointer != 16'h0000) begin
            redir <= '{valid: 1'b1, from_queue: 1'b0, target: dec.addr};
        end else begin
            redir <= '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aux_wr <= 1'b0;
            aux_pointer_nxt <= '0;
        end else begin
            aux_wr <= take && dec.op == ZOLC_OP_BR_AUX; // RQ19
            if (take && dec.op == ZOLC_OP_BR_AUX) begin
                aux_pointer_nxt <= aux_pointer - 16'h0001; // RQ19 RQ17
            end
        end
    end

    // branch overhead is paid as blocked decode cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovh_r <= 3'h0;
        end else if (take && dec.op == ZOLC_OP_BR_AUX) begin
            ovh_r <= ZOLC_BR_OVH_CYC; // RQ1
        end else if (ovh_r != 3'h0) begin
            ovh_r <= ovh_r - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] status;

    function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        merge_sel = r;
    endfunction

    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign status = {26'h0, (lc_pend_r != 2'h0), l1_local, l0_local, l1_active, l0_active,
                     (rpt_st_r == ZOLC_RPT_RUN)};

    always_comb begin
        unique case (wb_adr_i)
            ZOLC_REG_CSR: rd_mux = {16'h0000, computed_repeat_count};
            ZOLC_REG_ACTIVE_SINGLE_REPEAT_COUNTER: rd_mux = {16'h0000, active_single_repeat_counter};
            ZOLC_REG_OUTER: rd_mux = {16'h0000, outer_block_counter};
            ZOLC_REG_INNER: rd_mux = {16'h0000, inner_block_counter};
            ZOLC_REG_SHADOW: rd_mux = {16'h0000, inner_count_shadow};
            ZOLC_REG_STATUS: rd_mux = status;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        bus_wdat = merge_sel(rd_mux, wb_dat_i, wb_sel_i);
    end

    // one wait state; unmapped addresses still ack and read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd_mux;
        end
    end
endmodule
`default_nettype wire

/* verification/zolc_top_asserts.sv */
// zolc_top_asserts: port-level checks for the loop unit.
// assumes one core clock and async active-high reset; bound at the foot.
`default_nettype none
module zolc_top_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire zolc_pkg::zolc_dec_t dec,
    input wire logic exec_done,
    input wire logic irq_pending,
    input wire logic [zolc_pkg::ZOLC_CW-1:0] aux_pointer,
    input wire logic dec_ready,
    input wire logic rpt_hold,
    input wire zolc_pkg::zolc_redir_t redir,
    input wire logic aux_wr,
    input wire logic [zolc_pkg::ZOLC_CW-1:0] aux_pointer_nxt
);
    import zolc_pkg::*;
    // ----------------
    // helpers
    // ----------------
    logic take;
    logic rpt_op;
    assign take = dec.valid && dec_ready;
    assign rpt_op = dec.op inside {ZOLC_OP_RPT_K, ZOLC_OP_RPT_CSR, ZOLC_OP_RPT_CSR_TA, ZOLC_OP_RPT_CSR_K4};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----------------
    // properties
    // ----------------
    a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    a_bus_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held");
    a_rpt_hold_start: assert property (take && rpt_op && !irq_pending |=> rpt_hold && !dec_ready)
        else $error("repeat not started");
    a_rpt_hold_keep: assert property (rpt_hold && !exec_done && !irq_pending |=> rpt_hold)
        else $error("repeat ended early");
    a_irq_hold_drop: assert property (irq_pending && rpt_hold |=> !rpt_hold)
        else $error("repeat not interruptible");
    a_aux_decrement: assert property (take && dec.op == ZOLC_OP_BR_AUX && aux_pointer != 16'h0000
        |=> aux_wr && aux_pointer_nxt == $past(aux_pointer) - 16'h0001)
        else $error("aux decrement wrong");
    a_aux_overhead: assert property (take && dec.op == ZOLC_OP_BR_AUX |=> !dec_ready [*4])
        else $error("aux branch overhead short");
    a_aux_wr_pulse: assert property (aux_wr |=> !aux_wr)
        else $error("aux write held");
    a_redir_cause: assert property (redir.valid |-> $past(dec.valid) ##1 !redir.valid)
        else $error("redirect without cause");
    c_aux: cover property (take && dec.op == ZOLC_OP_BR_AUX);
    c_queue: cover property (redir.valid && redir.from_queue);
    c_fetch: cover property (redir.valid && !redir.from_queue);
    c_rpt_end: cover property ($fell(rpt_hold) && !irq_pending);
endmodule
bind zolc_top zolc_top_asserts u_zolc_chk (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dec(dec),
    .exec_done(exec_done), .irq_pending(irq_pending), .aux_pointer(aux_pointer), .dec_ready(dec_ready),
    .rpt_hold(rpt_hold), .redir(redir), .aux_wr(aux_wr), .aux_pointer_nxt(aux_pointer_nxt)
);
`default_nettype wire

/* verification/zolc_pipe_model.sv */
// zolc_pipe_model: execute pipeline stand-in retiring repeated slots.
// assumes rpt_hold from the loop unit; slow spaces retirements out.
`default_nettype none
module zolc_pipe_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic rpt_hold,
    input wire logic slow,
    output logic exec_done
);
    logic [1:0] wait_r;
    // one slot in flight, so at most one slot retires after hold has fallen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_r <= 2'h0;
            exec_done <= 1'b0;
        end else if (rpt_hold && !exec_done && wait_r == 2'h0) begin
            exec_done <= 1'b1;
            wait_r <= slow ? 2'h3 : 2'h0;
        end else begin
            exec_done <= 1'b0;
            wait_r <= (wait_r != 2'h0) ? wait_r - 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

/* verification/zolc_top_tb_top.sv */
// zolc_top_tb_top: self-checking bench for the loop unit.
// assumes zolc_pkg, the pipeline model and the bound checker.
`default_nettype none
module zolc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import zolc_pkg::*;
    logic clk, rst, cyc, stb, we, ack, exec_done, irq, slow, dec_ready, rpt_hold, aux_wr;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [15:0] tmp, ap, ap_nxt;
    zolc_dec_t dec;
    zolc_redir_t redir;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    zolc_top dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dec(dec), .exec_done(exec_done),
        .irq_pending(irq), .temp_addend_register(tmp), .aux_pointer(ap), .dec_ready(dec_ready),
        .rpt_hold(rpt_hold), .redir(redir), .aux_wr(aux_wr), .aux_pointer_nxt(ap_nxt));
    zolc_pipe_model u_pipe (.clk(clk), .rst(rst), .rpt_hold(rpt_hold), .slow(slow), .exec_done(exec_done));
    // ----------------
    // clock and timeout
    // ----------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    // ----------------
    // shared tasks
    // ----------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(q, e);
    endtask
    // holds the op until the unit takes it
    task issue(input zolc_op_t o, input logic [15:0] k, input logic [23:0] a, input logic [23:0] p);
        dec <= '{1'b1, o, k, a, p};
        do begin
            @(posedge clk);
        end while (dec_ready !== 1'b1);
        dec.valid <= 1'b0;
    endtask
    task count_for(input int k, inout int c);
        repeat (k) begin
            @(posedge clk);
            c += int'(exec_done === 1'b1);
        end
    endtask
    task drain(inout int c);
        int i;
        i = 0;
        do begin
            count_for(1, c);
            i++;
        end while (rpt_hold !== 1'b0 && i < 1000);
    endtask
    task at_end(input logic [23:0] pc, input logic e, input logic [23:0] t, input logic q);
        dec <= '{1'b1, ZOLC_OP_NONE, 16'h0, 24'h0, pc};
        @(posedge clk);
        dec.valid <= 1'b0;
        @(posedge clk);
        chk(32'(redir.valid), 32'(e));
        if (e) begin
            chk(32'(redir.target), 32'(t));
            chk(32'(redir.from_queue), 32'(q));
        end
    endtask
    // ----------------
    // scenarios
    // ----------------
    task t_regs();
        logic [31:0] q;
        for (logic [4:0] a = 5'h00; a <= 5'h18; a += 5'h04) begin
            rd(a, 32'h0);
        end
        wr(ZOLC_REG_ACTIVE_SINGLE_REPEAT_COUNTER, 32'h7);
        rd(ZOLC_REG_ACTIVE_SINGLE_REPEAT_COUNTER, 32'h0);
        wr(ZOLC_REG_CSR, 32'hFFFF_A5C3);
        bus(1'b1, ZOLC_REG_CSR, 32'h0000_3C00, 4'h2, q);
        rd(ZOLC_REG_CSR, 32'h0000_3CC3);
    endtask
    task t_rpt(input zolc_op_t o, input logic [15:0] k, input int n);
        int c;
        c = 0;
        @(posedge clk);
        issue(o, k, 24'h0, 24'h0);
        drain(c);
        chk(32'(c), 32'(n));
    endtask
    task t_csr();
        issue(ZOLC_OP_RD_LC, 16'h0, 24'h0, 24'h0);
        wr(ZOLC_REG_CSR, 32'h4);
        t_rpt(ZOLC_OP_RPT_CSR, 16'h0, 5);
        rd(ZOLC_REG_CSR, 32'h4);
        t_rpt(ZOLC_OP_RPT_CSR_K4, 16'h0003, 5);
        rd(ZOLC_REG_CSR, 32'h7);
        tmp <= 16'h0002;
        t_rpt(ZOLC_OP_RPT_CSR_TA, 16'h0, 8);
        rd(ZOLC_REG_CSR, 32'h9);
        issue(ZOLC_OP_WR_CSR, 16'h0002, 24'h0, 24'h0);
        rd(ZOLC_REG_STATUS, 32'h20);
        t_rpt(ZOLC_OP_RPT_CSR, 16'h0, 3);
        rd(ZOLC_REG_ACTIVE_SINGLE_REPEAT_COUNTER, 32'h0);
    endtask
    task t_irq();
        int c;
        c = 0;
        issue(ZOLC_OP_RPT_K, 16'h0005, 24'h0, 24'h0);
        count_for(4, c);
        irq <= 1'b1;
        count_for(4, c);
        chk(32'(rpt_hold), 32'h0);
        irq <= 1'b0;
        count_for(2, c);
        drain(c);
        chk(32'(c), 32'h6);
    endtask
    task t_aux(input logic [15:0] v);
        int n;
        ap <= v;
        issue(ZOLC_OP_BR_AUX, 16'h0, 24'h000200, 24'h000210);
        @(posedge clk);
        chk(32'(redir.valid), 32'(v != 16'h0));
        if (v != 16'h0) begin
            chk(32'(aux_wr), 32'h1);
            chk(32'(ap_nxt), 32'(v - 16'h1));
            chk(32'(redir.target), 32'h200);
        end
        n = 0;
        while (dec_ready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        chk(32'(n), 32'(ZOLC_BR_OVH_CYC));
    endtask
    task t_block();
        wr(ZOLC_REG_OUTER, 32'h1);
        wr(ZOLC_REG_INNER, 32'h2);
        rd(ZOLC_REG_SHADOW, 32'h2);
        issue(ZOLC_OP_BLK_LOCAL, 16'h0, 24'h000140, 24'h000100);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            issue(ZOLC_OP_BLK_STD, 16'h0, 24'h000120, 24'h000110);
            t_rpt(ZOLC_OP_RPT_K, 16'h0001, 2);
            for (int j = 0; j < 3; j++) begin
                at_end(24'h000120, j < 2, 24'h000110, 1'b0);
            end
            at_end(24'h000140, p == 0, 24'h000100, 1'b1);
        end
        rd(ZOLC_REG_OUTER, 32'h0);
        rd(ZOLC_REG_INNER, 32'h2);
    endtask
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 5'h00;
        sel = 4'hF;
        wdat = 32'h0;
        dec = '0;
        irq = 1'b0;
        slow = 1'b0;
        tmp = 16'h0;
        ap = 16'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_regs();
        t_csr();
        t_rpt(ZOLC_OP_RPT_K, 16'h0100, 257);
        slow <= 1'b1;
        t_rpt(ZOLC_OP_RPT_K, 16'h0002, 3);
        t_irq();
        t_aux(16'h0003);
        t_aux(16'h0000);
        t_block();
        final_report();
    end
endmodule
`default_nettype wire
